// >>> core/iqcg_capture.sv
// Functional notes
// [R1] Averaging count 0..32767, resets to 0
// [R2] Averaging needs acquisition; limits size 524288
// [R3] Readout offset and length ranges; none reads all
// [R4] Readout without captured data raises query error
// [R5] Commands refused until readout fully consumed
// [R6] Gating needs acquisition and EXT/IF_POWER_TRIGGER source
// [R7] Gate gap 1..limit samples, resets to 100
// [R8] Gate length 1..limit samples, resets to 100
// [R9] Gate periods per trigger 1..1023, reset 1
// [R10] Gate type level or edge, edge default
// [R11] Level gating with IF_POWER_TRIGGER ignores holdoff
// [R12] Evaluation needs acquisition; off means no traces
// [R13] Capture memory limited to 200 MS
// [R14] Acquisition on disables other functions, blanks traces
// [R15] Trigger position reported for EXT/IF_POWER_TRIGGER, else zero
// [R16] Edge gating records gate periods until count reached
// [R17] Level gating stores samples while gate high
// [R18] Pretrigger samples for all but free run; none here with gating or averaging either
// [R19] Gating set only through the register port
// [R20] Readout returns two values per sample
// [R21] Averaged sample is mean over data sets
`timescale 1ns/10ps
`default_nettype none
module iqcg_capture (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic [iqcg_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic [iqcg_pkg::DATA_W-1:0] reg_wdata_i,
    input wire logic reg_we_i,
    input wire logic reg_re_i,
    output logic [iqcg_pkg::DATA_W-1:0] reg_rdata_o,
    input wire logic sample_valid_i,
    input wire logic [15:0] sample_i_i,
    input wire logic [15:0] sample_q_i,
    input wire logic ext_trig_i,
    input wire logic if_power_trigger_i,
    input wire logic if_power_level_i,
    output logic other_meas_off_o,
    output logic trace_blank_o,
    output logic evaluation_mode_o,
    output logic capture_busy_o,
    output logic readout_busy_o,
    output logic query_error_o
);
    import iqcg_pkg::*;

    // Clamp a value into a closed range
    function automatic logic [27:0] clamp(input logic [27:0] v, input logic [27:0] lo, input logic [27:0] hi);
        clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    // Map a logical pretrigger index onto the ring slot holding it
    function automatic logic [27:0] ring_map(input logic [27:0] base, input logic [27:0] idx,
                                             input logic [27:0] len);
        logic [28:0] s;
        s = {1'b0, base} + {1'b0, idx};
        ring_map = (s >= {1'b0, len}) ? 28'(s - {1'b0, len}) : s[27:0];
    endfunction

    // Mean of an accumulated sum over a number of sets
    function automatic logic [31:0] mean(input logic signed [31:0] sum, input logic [15:0] n);
        mean = 32'(sum / $signed({1'b0, n}));
    endfunction

    // Configuration registers
    logic acq_q;
    logic avg_q;
    logic gate_q;
    logic level_q;
    logic evaluation_mode_q;
    logic [1:0] src_q;
    logic slope_q;
    logic [14:0] avg_cnt_q;
    logic [23:0] gap_q;
    logic [23:0] glen_q;
    logic [9:0] gper_q;
    logic [27:0] pre_q;
    logic [27:0] rec_q;
    logic [27:0] rd_off_q;
    logic [27:0] rd_cnt_q;
    logic qerr_q;
    // Capture sequencer state
    iqcg_state_t st_q;
    logic [27:0] wr_q;
    logic [27:0] ring_q;
    logic [27:0] fill_q;
    logic [27:0] base_q;
    logic [27:0] pre_used_q;
    logic [27:0] len_q;
    logic [27:0] cap_len_q;
    logic captured_q;
    logic [14:0] set_q;
    logic [15:0] avg_n_q;
    logic [9:0] per_q;
    logic [23:0] gcnt_q;
    logic gon_q;
    logic [27:0] trigger_position_in_sample_q;
    // Readout state
    logic ro_busy_q;
    logic [27:0] ro_idx_q;
    logic [28:0] ro_left_q;
    logic ro_qhalf_q;
    // Pin synchronisers, third stage only for edge detection
    logic [2:0] sync1_q;
    logic [2:0] sync2_q;
    logic [1:0] prev_q;
    // Sample memory holding running sums
    logic signed [31:0] mem_i [MEM_WORDS];
    logic signed [31:0] mem_q [MEM_WORDS];

    // Register writes are refused while a readout is pending
    wire wr_ok = reg_we_i & ~ro_busy_q; // see [R5]
    wire wr_ctrl = wr_ok & (reg_addr_i == OFF_CTRL);
    wire wr_cmd = wr_ok & (reg_addr_i == OFF_CMD);
    wire [1:0] new_src = reg_wdata_i[CTRL_SRC_LO+1:CTRL_SRC_LO];
    wire new_src_trig = (new_src == SRC_EXT) | (new_src == SRC_IFP);

    // Effective mode terms
    wire src_trig = (src_q == SRC_EXT) | (src_q == SRC_IFP);
    wire gating = gate_q & acq_q & src_trig; // see [R6]
    wire avg_act = avg_q & acq_q;
    wire [27:0] avg_lim = avg_act ? ((rec_q > AVG_MAX_SAMPLES) ? AVG_MAX_SAMPLES : rec_q) : rec_q; // see [R2]
    wire [27:0] eff_len = (avg_lim > MEM_LIMIT) ? MEM_LIMIT : avg_lim; // see [R13]
    wire no_pre = (src_q == SRC_FREE) | gating | avg_act;
    wire [27:0] pre_eff = no_pre ? 28'h0 : ((pre_q >= eff_len) ? 28'(eff_len - 28'h1) : pre_q); // see [R18]

    // Trigger polarity and edges on synchronised pins
    wire ext_pol = sync2_q[0] ^ slope_q;
    wire ifp_pol = sync2_q[1] ^ slope_q;
    wire ext_edge = ext_pol & ~(prev_q[0] ^ slope_q);
    wire ifp_edge = ifp_pol & ~(prev_q[1] ^ slope_q);
    // Two-sample history of the synchronised level, newest in bit 0
    logic [1:0] lvl_hist_q;
    wire raw_rise = lvl_hist_q[0] & ~lvl_hist_q[1];
    // Level gating on IF_POWER_TRIGGER uses the raw level, bypassing holdoff
    wire lvl_ifp = gating & level_q & (src_q == SRC_IFP); // see [R11]
    wire trig = (src_q == SRC_FREE) ? 1'b1 : ((src_q == SRC_EXT) ? ext_edge : (lvl_ifp ? raw_rise : ifp_edge));
    wire gate_lvl = (src_q == SRC_EXT) ? ext_pol : lvl_hist_q[0];

    // Sample acceptance in each phase
    wire pre_full = fill_q >= pre_used_q;
    wire take_trig = trig & pre_full;
    wire ring_wr = sample_valid_i & (st_q == CAP_ARM) & (pre_used_q != 28'h0) & ~take_trig;
    wire gate_pass = ~gating | (level_q ? gate_lvl : gon_q); // see [R17]
    wire rec_wr = sample_valid_i & (st_q == CAP_REC) & gate_pass;
    wire [27:0] wr_addr = ring_wr ? ring_q : wr_q;
    wire [MEM_AW-1:0] mem_wa = wr_addr[MEM_AW-1:0];
    wire first_set = (set_q == 15'h0);
    wire set_last = (16'(set_q) + 16'h1) >= avg_n_q;
    wire rec_end = rec_wr & ((wr_q + 28'h1) == len_q);
    wire [23:0] gcnt_nx = gcnt_q + 24'h1;

    // Readout request validation
    wire [27:0] avail = cap_len_q;
    wire [27:0] ro_cnt = (rd_cnt_q == 28'h0) ? 28'(avail - rd_off_q) : rd_cnt_q; // see [R3]
    wire ro_ok = captured_q & (rd_off_q < avail) & (ro_cnt >= 28'h1) & (ro_cnt <= 28'(avail - rd_off_q));
    wire ro_req = wr_cmd & reg_wdata_i[CMD_READOUT];
    wire cap_req = wr_cmd & reg_wdata_i[CMD_CAPTURE] & acq_q & (st_q == CAP_IDLE);
    wire ro_pop = reg_re_i & ro_busy_q & (reg_addr_i == OFF_RD_DATA);
    wire [27:0] ro_phys = (ro_idx_q < pre_used_q) ? ring_map(base_q, ro_idx_q, pre_used_q) : ro_idx_q;
    wire [MEM_AW-1:0] ro_ra = ro_phys[MEM_AW-1:0];
    wire [31:0] ro_val = ro_qhalf_q ? mean(mem_q[ro_ra], avg_n_q) : mean(mem_i[ro_ra], avg_n_q); // see [R21]

    // Read data selection
    wire [31:0] ctrl_rd = {24'h0, slope_q, src_q, evaluation_mode_q, level_q, gate_q, avg_q, acq_q};
    wire [31:0] stat_rd = {28'h0, ro_busy_q, st_q != CAP_IDLE, captured_q, qerr_q};
    wire [31:0] rd_mux =
        (reg_addr_i == OFF_CTRL) ? ctrl_rd :
        (reg_addr_i == OFF_AVG_CNT) ? {17'h0, avg_cnt_q} :
        (reg_addr_i == OFF_GATE_GAP) ? {8'h0, gap_q} :
        (reg_addr_i == OFF_GATE_LEN) ? {8'h0, glen_q} :
        (reg_addr_i == OFF_GATE_PER) ? {22'h0, gper_q} :
        (reg_addr_i == OFF_PRETRIG) ? {4'h0, pre_q} :
        (reg_addr_i == OFF_REC_LEN) ? {4'h0, rec_q} :
        (reg_addr_i == OFF_RD_OFF) ? {4'h0, rd_off_q} :
        (reg_addr_i == OFF_RD_CNT) ? {4'h0, rd_cnt_q} :
        (reg_addr_i == OFF_RD_DATA) ? (ro_busy_q ? ro_val : 32'h0) :
        (reg_addr_i == OFF_STATUS) ? stat_rd :
        (reg_addr_i == OFF_TRIGGER_POSITION_IN_SAMPLE) ? {4'h0, trigger_position_in_sample_q} : 32'h0;

    // Two-flop synchronisers plus history for edges
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            sync1_q <= 3'h0;
            sync2_q <= 3'h0;
            prev_q <= 2'h0;
            lvl_hist_q <= 2'h0;
        end else begin
            sync1_q <= {if_power_level_i, if_power_trigger_i, ext_trig_i};
            sync2_q <= sync1_q;
            prev_q <= sync2_q[1:0];
            lvl_hist_q <= {lvl_hist_q[0], sync2_q[2]};
        end
    end

    // Control register; dependent modes only enable with acquisition on
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            acq_q <= 1'b0; // see [R14]
            avg_q <= 1'b0; // see [R2]
            gate_q <= 1'b0; // see [R6]
            level_q <= 1'b0; // see [R10]
            evaluation_mode_q <= 1'b0; // see [R12]
            src_q <= SRC_FREE;
            slope_q <= 1'b0;
        end else if (wr_ctrl) begin
            // Gating is reachable only here, through the register port
            acq_q <= reg_wdata_i[CTRL_ACQ]; // see [R19]
            avg_q <= reg_wdata_i[CTRL_AVG] & acq_q & reg_wdata_i[CTRL_ACQ]; // see [R2]
            gate_q <= reg_wdata_i[CTRL_GATE] & acq_q & reg_wdata_i[CTRL_ACQ] & new_src_trig; // see [R6]
            level_q <= reg_wdata_i[CTRL_LEVEL]; // see [R10]
            evaluation_mode_q <= reg_wdata_i[CTRL_EVALUATION_MODE] & acq_q & reg_wdata_i[CTRL_ACQ]; // see [R12]
            src_q <= (new_src == 2'h3) ? SRC_FREE : new_src;
            slope_q <= reg_wdata_i[CTRL_SLOPE];
        end
    end

    // Numeric settings, each but readout offset and count clamped into its legal range
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            avg_cnt_q <= RST_AVG_CNT; // see [R1]
            gap_q <= RST_GATE_GAP; // see [R7]
            glen_q <= RST_GATE_LEN; // see [R8]
            gper_q <= RST_GATE_PER; // see [R9]
            pre_q <= RST_PRETRIG;
            rec_q <= RST_REC_LEN;
            rd_off_q <= 28'h0;
            rd_cnt_q <= 28'h0;
        end else if (wr_ok) begin
            if (reg_addr_i == OFF_AVG_CNT) begin
                avg_cnt_q <= (reg_wdata_i > {17'h0, MAX_AVG_CNT}) ? MAX_AVG_CNT : reg_wdata_i[14:0]; // see [R1]
            end else if (reg_addr_i == OFF_GATE_GAP) begin
                gap_q <= 24'(clamp(reg_wdata_i[27:0], 28'h1, {4'h0, GATE_MAX})); // see [R7]
            end else if (reg_addr_i == OFF_GATE_LEN) begin
                glen_q <= 24'(clamp(reg_wdata_i[27:0], 28'h1, {4'h0, GATE_MAX})); // see [R8]
            end else if (reg_addr_i == OFF_GATE_PER) begin
                gper_q <= 10'(clamp(reg_wdata_i[27:0], 28'h1, {18'h0, MAX_GATE_PER})); // see [R9]
            end else if (reg_addr_i == OFF_PRETRIG) begin
                pre_q <= clamp(reg_wdata_i[27:0], 28'h0, 28'(MAX_REC_LEN - 28'h1));
            end else if (reg_addr_i == OFF_REC_LEN) begin
                rec_q <= clamp(reg_wdata_i[27:0], 28'h1, MAX_REC_LEN); // see [R13]
            end else if (reg_addr_i == OFF_RD_OFF) begin
                rd_off_q <= reg_wdata_i[27:0];
            end else if (reg_addr_i == OFF_RD_CNT) begin
                rd_cnt_q <= reg_wdata_i[27:0];
            end
        end
    end

    // Capture sequencer: arm with pretrigger ring, record, re-arm per gate burst
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            st_q <= CAP_IDLE;
            wr_q <= 28'h0;
            ring_q <= 28'h0;
            fill_q <= 28'h0;
            base_q <= 28'h0;
            pre_used_q <= 28'h0;
            len_q <= 28'h0;
            cap_len_q <= 28'h0;
            captured_q <= 1'b0;
            set_q <= 15'h0;
            avg_n_q <= 16'h1;
            per_q <= 10'h0;
            gcnt_q <= 24'h0;
            gon_q <= 1'b0;
            trigger_position_in_sample_q <= 28'h0;
        end else if (~acq_q) begin
            st_q <= CAP_IDLE;
        end else begin
            case (st_q)
                CAP_IDLE: begin
                    if (cap_req) begin
                        st_q <= CAP_ARM;
                        len_q <= eff_len;
                        pre_used_q <= pre_eff; // see [R18]
                        avg_n_q <= (avg_act && avg_cnt_q != 15'h0) ? {1'b0, avg_cnt_q} : 16'h1; // see [R21]
                        set_q <= 15'h0;
                        fill_q <= 28'h0;
                        ring_q <= 28'h0;
                        wr_q <= 28'h0;
                        captured_q <= 1'b0;
                    end
                end
                CAP_ARM: begin
                    // Pretrigger ring fills until the trigger is taken
                    if (take_trig) begin
                        st_q <= CAP_REC;
                        base_q <= ring_q;
                        wr_q <= pre_used_q;
                        gon_q <= 1'b1;
                        gcnt_q <= 24'h0;
                        per_q <= 10'h0;
                        trigger_position_in_sample_q <= src_trig ? pre_used_q : 28'h0; // see [R15]
                    end else if (ring_wr) begin
                        ring_q <= ((ring_q + 28'h1) == pre_used_q) ? 28'h0 : 28'(ring_q + 28'h1);
                        fill_q <= pre_full ? fill_q : 28'(fill_q + 28'h1);
                    end
                end
                CAP_REC: begin
                    if (rec_end) begin
                        // Next data set or finished
                        st_q <= set_last ? CAP_IDLE : CAP_ARM;
                        set_q <= set_last ? set_q : 15'(set_q + 15'h1);
                        captured_q <= set_last;
                        cap_len_q <= set_last ? len_q : cap_len_q;
                        wr_q <= 28'h0;
                    end else begin
                        if (rec_wr) begin
                            wr_q <= 28'(wr_q + 28'h1);
                        end
                        // Edge gating: alternate gate length and gap
                        if (sample_valid_i && gating && !level_q) begin
                            if (gon_q && gcnt_nx == glen_q) begin
                                gon_q <= 1'b0;
                                gcnt_q <= 24'h0;
                                per_q <= 10'(per_q + 10'h1);
                                st_q <= ((per_q + 10'h1) == gper_q) ? CAP_REARM : CAP_REC; // see [R9]
                            end else if (!gon_q && gcnt_nx == gap_q) begin
                                gon_q <= 1'b1; // see [R16]
                                gcnt_q <= 24'h0;
                            end else begin
                                gcnt_q <= gcnt_nx;
                            end
                        end
                    end
                end
                CAP_REARM: begin
                    // Next trigger opens a fresh burst of gate periods
                    if (trig) begin
                        st_q <= CAP_REC; // see [R16]
                        gon_q <= 1'b1;
                        gcnt_q <= 24'h0;
                        per_q <= 10'h0;
                    end
                end
                default: st_q <= CAP_IDLE;
            endcase
        end
    end

    // Sample memory: first set stores, later sets accumulate
    always_ff @(posedge core_clk_i) begin
        if (ring_wr || rec_wr) begin
            mem_i[mem_wa] <= first_set ? 32'($signed(sample_i_i)) : mem_i[mem_wa] + 32'($signed(sample_i_i));
            mem_q[mem_wa] <= first_set ? 32'($signed(sample_q_i)) : mem_q[mem_wa] + 32'($signed(sample_q_i));
        end
    end

    // Readout engine, I then Q per sample, and query error flag
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            ro_busy_q <= 1'b0;
            ro_idx_q <= 28'h0;
            ro_left_q <= 29'h0;
            ro_qhalf_q <= 1'b0;
            qerr_q <= 1'b0;
        end else begin
            if (ro_req && ro_ok) begin
                ro_busy_q <= 1'b1; // see [R5]
                ro_idx_q <= rd_off_q;
                ro_left_q <= {ro_cnt, 1'b0}; // see [R20]
                ro_qhalf_q <= 1'b0;
            end else if (ro_pop) begin
                ro_qhalf_q <= ~ro_qhalf_q;
                ro_idx_q <= ro_qhalf_q ? 28'(ro_idx_q + 28'h1) : ro_idx_q;
                ro_left_q <= 29'(ro_left_q - 29'h1);
                ro_busy_q <= (ro_left_q != 29'h1);
            end
            // Set wins over a software clear in the same cycle
            if (ro_req && !ro_ok) begin
                qerr_q <= 1'b1; // see [R4]
            end else if (wr_ok && reg_addr_i == OFF_STATUS && reg_wdata_i[ST_QERR]) begin
                qerr_q <= 1'b0;
            end
        end
    end

    // Registered outputs
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            reg_rdata_o <= 32'h0;
            other_meas_off_o <= 1'b0;
            trace_blank_o <= 1'b0;
            evaluation_mode_o <= 1'b0;
            capture_busy_o <= 1'b0;
            readout_busy_o <= 1'b0;
            query_error_o <= 1'b0;
        end else begin
            reg_rdata_o <= reg_re_i ? rd_mux : 32'h0;
            other_meas_off_o <= acq_q; // see [R14]
            trace_blank_o <= acq_q & ~evaluation_mode_q; // see [R12]
            evaluation_mode_o <= evaluation_mode_q;
            capture_busy_o <= (st_q != CAP_IDLE);
            readout_busy_o <= ro_busy_q;
            query_error_o <= qerr_q;
        end
    end
endmodule
`default_nettype wire

// >>> core/iqcg_pkg.sv
package iqcg_pkg;
    // Register port geometry
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    // Register word offsets
    localparam logic [3:0] OFF_CTRL = 4'h0;
    localparam logic [3:0] OFF_AVG_CNT = 4'h1;
    localparam logic [3:0] OFF_GATE_GAP = 4'h2;
    localparam logic [3:0] OFF_GATE_LEN = 4'h3;
    localparam logic [3:0] OFF_GATE_PER = 4'h4;
    localparam logic [3:0] OFF_PRETRIG = 4'h5;
    localparam logic [3:0] OFF_REC_LEN = 4'h6;
    localparam logic [3:0] OFF_CMD = 4'h7;
    localparam logic [3:0] OFF_RD_OFF = 4'h8;
    localparam logic [3:0] OFF_RD_CNT = 4'h9;
    localparam logic [3:0] OFF_RD_DATA = 4'hA;
    localparam logic [3:0] OFF_STATUS = 4'hB;
    localparam logic [3:0] OFF_TRIGGER_POSITION_IN_SAMPLE = 4'hC;
    // Control register bit positions
    localparam int CTRL_ACQ = 0;
    localparam int CTRL_AVG = 1;
    localparam int CTRL_GATE = 2;
    localparam int CTRL_LEVEL = 3;
    localparam int CTRL_EVALUATION_MODE = 4;
    localparam int CTRL_SRC_LO = 5;
    localparam int CTRL_SLOPE = 7;
    // Command and status bit positions
    localparam int CMD_CAPTURE = 0;
    localparam int CMD_READOUT = 1;
    localparam int ST_QERR = 0;
    localparam int ST_CAPTURED = 1;
    localparam int ST_CAP_BUSY = 2;
    localparam int ST_RO_BUSY = 3;
    // Trigger sources
    localparam logic [1:0] SRC_FREE = 2'h0;
    localparam logic [1:0] SRC_EXT = 2'h1;
    localparam logic [1:0] SRC_IFP = 2'h2;
    // Values after reset
    localparam logic [14:0] RST_AVG_CNT = 15'h0000;
    localparam logic [23:0] RST_GATE_GAP = 24'h000064;
    localparam logic [23:0] RST_GATE_LEN = 24'h000064;
    localparam logic [9:0] RST_GATE_PER = 10'h001;
    localparam logic [27:0] RST_PRETRIG = 28'h0000000;
    localparam logic [27:0] RST_REC_LEN = 28'h0000080;
    // Limits
    localparam logic [14:0] MAX_AVG_CNT = 15'h7FFF;
    localparam logic [27:0] AVG_MAX_SAMPLES = 28'h0080000;
    localparam logic [27:0] MAX_REC_LEN = 28'hC800000;
    localparam logic [23:0] GATE_MAX = 24'hFFFFFF;
    localparam logic [9:0] MAX_GATE_PER = 10'h3FF;
    // Physical sample memory
    localparam int MEM_AW = 10;
    localparam int MEM_WORDS = 1024;
    localparam logic [27:0] MEM_LIMIT = 28'h0000400;
    // Capture sequencer states
    typedef enum logic [1:0] {
        CAP_IDLE,
        CAP_ARM,
        CAP_REC,
        CAP_REARM
    } iqcg_state_t;
endpackage

// >>> test/iqcg_capture_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module iqcg_capture_checker (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic [iqcg_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic [iqcg_pkg::DATA_W-1:0] reg_wdata_i,
    input wire logic reg_we_i,
    input wire logic reg_re_i,
    input wire logic [iqcg_pkg::DATA_W-1:0] reg_rdata_o,
    input wire logic other_meas_off_o,
    input wire logic trace_blank_o,
    input wire logic evaluation_mode_o,
    input wire logic readout_busy_o,
    input wire logic query_error_o
);
    import iqcg_pkg::*;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    // Readout command while the port is idle
    sequence s_ro_req;
        reg_we_i && reg_addr_i == OFF_CMD && reg_wdata_i[CMD_READOUT] && !readout_busy_o;
    endsequence
    // Command-word write taken two cycles back
    sequence s_cmd_past;
        $past(reg_we_i, 2) && $past(reg_addr_i, 2) == OFF_CMD;
    endsequence
    // Data pop taken two cycles back
    sequence s_pop_past;
        $past(reg_re_i, 2) && $past(reg_addr_i, 2) == OFF_RD_DATA;
    endsequence
    a_rdata_idle: assert property (!reg_re_i |=> reg_rdata_o == '0)
        else $error("read data not zero outside a read answer");
    a_unmapped_zero: assert property (reg_re_i && reg_addr_i > OFF_TRIGGER_POSITION_IN_SAMPLE |=> reg_rdata_o == '0)
        else $error("unmapped read returned data");
    a_cmd_reads_zero: assert property (reg_re_i && reg_addr_i == OFF_CMD |=> reg_rdata_o == '0)
        else $error("command word read back nonzero");
    a_blank_needs_acq: assert property (trace_blank_o |-> other_meas_off_o && !evaluation_mode_o)
        else $error("traces blanked without acquisition or with evaluation");
    a_evaluation_mode_needs_acq: assert property (evaluation_mode_o |-> other_meas_off_o)
        else $error("evaluation on without acquisition");
    a_ro_end_pop: assert property ($fell(readout_busy_o) |-> s_pop_past)
        else $error("readout ended without a final pop");
    a_ro_answer: assert property (s_ro_req |-> ##[1:3] (readout_busy_o || query_error_o))
        else $error("readout command gave neither data nor error");
    a_qerr_cause: assert property ($rose(query_error_o) |-> s_cmd_past)
        else $error("query error without a readout command");
endmodule
bind iqcg_capture iqcg_capture_checker iqcg_capture_checker_inst (.core_clk_i, .rst_i, .reg_addr_i,
    .reg_wdata_i, .reg_we_i, .reg_re_i, .reg_rdata_o, .other_meas_off_o, .trace_blank_o,
    .evaluation_mode_o, .readout_busy_o, .query_error_o);
`default_nettype wire

// >>> test/iqcg_sample_src.sv
`timescale 1ns/10ps
`default_nettype none
module iqcg_sample_src (
    input wire logic core_clk_i,
    input wire logic rst_i,
    output logic sample_valid_o,
    output logic [15:0] sample_i_o,
    output logic [15:0] sample_q_o
);
    logic [15:0] ramp_q; // Ramp of sample values
    // Ramp so each stored index is distinct; Q is minus I so pairing slips show
    always_ff @(posedge core_clk_i) begin
        ramp_q <= rst_i ? 16'h0000 : ramp_q + 16'h0001;
    end
    assign sample_valid_o = !rst_i;
    assign sample_i_o = ramp_q;
    assign sample_q_o = 16'h0000 - ramp_q;
endmodule
`default_nettype wire

// >>> test/iq_capture_gating_buffer_test.sv
`timescale 1ns/10ps
`default_nettype none
module iq_capture_gating_buffer_test;
    import iqcg_pkg::*;
    logic clk = 1'b0; // Core clock
    logic rst = 1'b1; // Synchronous reset
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0, rdata, v, i1, q1, i2;
    logic we = 1'b0, re = 1'b0, ext = 1'b0;
    logic sv, meas_off, blank, evaluation_mode, cap_busy, ro_busy, qerr;
    logic [15:0] si, sq;
    int fails = 0, checks = 0, cyc = 0;
    always #2.5 clk = ~clk;
    iqcg_sample_src iqcg_sample_src_inst (.core_clk_i(clk), .rst_i(rst), .sample_valid_o(sv),
        .sample_i_o(si), .sample_q_o(sq));
    iqcg_capture iqcg_capture_inst (.core_clk_i(clk), .rst_i(rst), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_we_i(we), .reg_re_i(re), .reg_rdata_o(rdata), .sample_valid_i(sv), .sample_i_i(si),
        .sample_q_i(sq), .ext_trig_i(ext), .if_power_trigger_i(1'b0), .if_power_level_i(1'b0),
        .other_meas_off_o(meas_off), .trace_blank_o(blank), .evaluation_mode_o(evaluation_mode),
        .capture_busy_o(cap_busy), .readout_busy_o(ro_busy), .query_error_o(qerr));
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic flag(input string what, input logic seen, input logic exp);
        check(what, {31'h0, seen}, {31'h0, exp});
    endtask
    // One-cycle write strobe
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        we <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        we <= 1'b0;
    endtask
    // One-cycle read strobe; data taken in the following cycle
    task automatic rd(input logic [3:0] a);
        @(posedge clk);
        re <= 1'b1;
        addr <= a;
        @(posedge clk);
        re <= 1'b0;
        #1 v = rdata;
    endtask
    task automatic rchk(input logic [3:0] a, input logic [31:0] e);
        rd(a);
        check($sformatf("reg %h", a), v, e);
    endtask
    // Poll a status bit until it clears, bounded
    task automatic wait_st(input int b);
        rd(OFF_STATUS);
        for (int n = 0; n < 40 && v[b] !== 1'b0; n++) rd(OFF_STATUS);
        flag("status bit", v[b], 1'b0);
    endtask
    // Readout of two samples; the offset write inside must be refused
    task automatic ro4;
        wr(OFF_CMD, 32'h2);
        wr(OFF_RD_OFF, 32'h3);
        rd(OFF_RD_DATA);
        i1 = v;
        rd(OFF_RD_DATA);
        q1 = v;
        rd(OFF_RD_DATA);
        i2 = v;
        rd(OFF_RD_DATA);
        check("pair q", q1, 32'h0 - i1);
        check("next q", v, 32'h0 - i2);
        check("next i", i2, i1 + 32'h1);
        rchk(OFF_RD_OFF, 32'h1);
        flag("ro_busy", ro_busy, 1'b0);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            tally_and_finish;
        end
    end
    initial begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rchk(OFF_CTRL, 32'h0);
        rchk(OFF_AVG_CNT, 32'h0);
        rchk(OFF_GATE_GAP, 32'h64);
        rchk(OFF_GATE_LEN, 32'h64);
        rchk(OFF_GATE_PER, 32'h1);
        wr(OFF_CTRL, 32'h16);
        rchk(OFF_CTRL, 32'h0);
        wr(OFF_CTRL, 32'h1);
        wr(OFF_CTRL, 32'h5);
        rchk(OFF_CTRL, 32'h1);
        flag("blank", blank, 1'b1);
        flag("meas_off", meas_off, 1'b1);
        wr(OFF_CTRL, 32'h3F);
        rchk(OFF_CTRL, 32'h3F);
        flag("evaluation_mode", evaluation_mode, 1'b1);
        flag("blank", blank, 1'b0);
        wr(OFF_AVG_CNT, 32'hFFFF);
        rchk(OFF_AVG_CNT, 32'h7FFF);
        wr(OFF_GATE_PER, 32'h7FF);
        rchk(OFF_GATE_PER, 32'h3FF);
        wr(OFF_CMD, 32'h2);
        rchk(OFF_STATUS, 32'h1);
        flag("qerr", qerr, 1'b1);
        wr(OFF_STATUS, 32'h1);
        rchk(OFF_STATUS, 32'h0);
        rchk(OFF_CMD, 32'h0);
        rchk(4'hF, 32'h0);
        // Free-run capture of four samples
        wr(OFF_CTRL, 32'h1);
        wr(OFF_PRETRIG, 32'h3);
        wr(OFF_REC_LEN, 32'h4);
        wr(OFF_CMD, 32'h1);
        wait_st(ST_CAP_BUSY);
        rchk(OFF_TRIGGER_POSITION_IN_SAMPLE, 32'h0);
        wr(OFF_RD_OFF, 32'h1);
        wr(OFF_RD_CNT, 32'h2);
        ro4;
        // Mean over two data sets
        wr(OFF_CTRL, 32'h3);
        wr(OFF_AVG_CNT, 32'h2);
        rchk(OFF_CTRL, 32'h3);
        wr(OFF_CMD, 32'h1);
        wait_st(ST_CAP_BUSY);
        ro4;
        // Offset at the sample count is out of range
        wr(OFF_RD_OFF, 32'h4);
        wr(OFF_CMD, 32'h2);
        rchk(OFF_STATUS, 32'h3);
        wr(OFF_STATUS, 32'h1);
        // External trigger capture with pretrigger
        wr(OFF_CTRL, 32'h21);
        wr(OFF_CMD, 32'h1);
        repeat (8) @(posedge clk);
        flag("cap_busy", cap_busy, 1'b1);
        ext <= 1'b1;
        repeat (4) @(posedge clk);
        ext <= 1'b0;
        wait_st(ST_CAP_BUSY);
        flag("cap_busy", cap_busy, 1'b0);
        rchk(OFF_TRIGGER_POSITION_IN_SAMPLE, 32'h3);
        tally_and_finish;
    end
endmodule
`default_nettype wire
